// ---- hw/bitband_pkg.sv ----
// constants and carriers for the alias remapper
// assumes one bus clock and a simple request/answer memory port
package bitband_pkg;
   localparam logic [31:0] SRAM_BAND_BASE = 32'h2000_0000;
   localparam logic [31:0] SRAM_BAND_LAST = 32'h2000_1FFF;
   localparam logic [31:0] SRAM_ALIAS_BASE = 32'h2200_0000;
   localparam logic [31:0] SRAM_ALIAS_LAST = 32'h2203_FFFF;
   localparam logic [31:0] PERI_BAND_BASE = 32'h4000_0000;
   localparam logic [31:0] PERI_BAND_LAST = 32'h400F_FFFF;
   localparam logic [31:0] PERI_ALIAS_BASE = 32'h4200_0000;
   localparam logic [31:0] PERI_ALIAS_LAST = 32'h43FF_FFFF;
   localparam logic [31:0] PERI_REGION_BASE = 32'h4000_0000;
   localparam logic [31:0] PERI_REGION_LAST = 32'h5FFF_FFFF;
   localparam int BAND_OFFSET_BITS = 20;
   localparam int ALIAS_BYTE_LSB = 5;
   localparam int ALIAS_BIT_LSB = 2;
   localparam logic [31:0] ALIAS_READ_SET = 32'h0000_0001;
   localparam logic [31:0] ALIAS_READ_CLEAR = 32'h0000_0000;
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;

   typedef struct packed {
      logic [31:0] addr;
      logic [1:0] size;
      logic write;
      logic fetch;
      logic [31:0] wdata;
   } request_t;

   typedef struct packed {
      logic [31:0] rdata;
      logic error;
   } answer_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_PASS = 3'h1,
      ST_RD = 3'h2,
      ST_WR = 3'h3,
      ST_DONE = 3'h4
   } state_t;
endpackage : bitband_pkg

// ---- hw/bitband_hold.sv ----
// request holding register for the remapper
// assumes load is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module bitband_hold (
   input wire logic mclk,
   input wire logic rst,
   input wire logic load,
   input wire bitband_pkg::request_t din,
   output bitband_pkg::request_t dout
);
   bitband_pkg::request_t hold_reg;
   bitband_pkg::request_t hold_next;

   always_comb begin
      hold_next = hold_reg;
      if (load) begin
         hold_next = din;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         hold_reg <= '0;
      end else begin
         hold_reg <= hold_next;
      end
   end

   assign dout = hold_reg;
endmodule : bitband_hold
`default_nettype wire

// ---- hw/bit_band_alias_remapper.sv ----
// alias window remapper between master data bus and memory port
// assumes master holds a request until upVld/upRdy handshake, one outstanding
// access; memory answers dnDone one or more cycles after dnVld taken
`timescale 1ns/1ps
`default_nettype none
// Function
// - the low SRAM band is passed through directly and also reachable via its alias window.
// - data accesses in the SRAM alias window go to the matching band bit, fetches are not remapped.
// - data accesses to the peripheral band are passed through directly and also reachable via its alias window.
// - data accesses in the peripheral alias window go to the band bit, fetches there are refused.
// - an alias write becomes read, single-bit change and write back inside this block.
// - alias offset divided by 32 gives the byte, bits 4:2 give the bit number.
// - the decoded bit number picks one of eight bits in the band byte.
// - the remapped memory access keeps the size of the alias access.
// - bit 0 of alias write data is the new value of the target bit.
// - alias write data bits 31 to 1 are ignored.
// - an alias read returns 1 when the bit is set and 0 when clear.
// - the peripheral band is the lowest 1 MB of its region with a 32 MB alias window; the SRAM band is 8 KB with a 256 KB window.
// - memory is byte addressed little-endian, lowest address in the low lane.
// - the peripheral region never permits instruction fetch.
module bit_band_alias_remapper (
   input wire logic mclk,
   input wire logic rst,
   input wire logic upVld,
   output logic upRdy,
   input wire bitband_pkg::request_t upReq,
   output logic upDone,
   output bitband_pkg::answer_t upAns,
   output logic dnVld,
   input wire logic dnRdy,
   output bitband_pkg::request_t dnReq,
   input wire logic dnDone,
   input wire bitband_pkg::answer_t dnAns
);
   bitband_pkg::state_t stateReg;
   bitband_pkg::state_t stateNext;
   logic issuedReg;
   logic issuedNext;
   logic [31:0] rdReg;
   logic [31:0] rdNext;
   bitband_pkg::answer_t ansReg;
   bitband_pkg::answer_t ansNext;
   bitband_pkg::request_t held;
   logic take;
   logic heldAlias;
   logic [31:0] targetAddr;
   logic [4:0] bitIdx;
   logic [31:0] wbData;

   function automatic logic inRange(
      input logic [31:0] a,
      input logic [31:0] lo,
      input logic [31:0] hi
   );
      return (a >= lo) && (a <= hi);
   endfunction : inRange

   function automatic logic inPeriAlias(input logic [31:0] a);
      return inRange(a, bitband_pkg::PERI_ALIAS_BASE, bitband_pkg::PERI_ALIAS_LAST);
   endfunction : inPeriAlias

   function automatic logic isAlias(input logic [31:0] a);
      logic sramHit;
      sramHit = inRange(a, bitband_pkg::SRAM_ALIAS_BASE, bitband_pkg::SRAM_ALIAS_LAST);
      return sramHit || inPeriAlias(a);
   endfunction : isAlias

   function automatic logic isPeriRegion(input logic [31:0] a);
      return inRange(a, bitband_pkg::PERI_REGION_BASE, bitband_pkg::PERI_REGION_LAST);
   endfunction : isPeriRegion

   // offset of the alias word inside its own window
   function automatic logic [31:0] aliasOffset(input logic [31:0] a);
      logic [31:0] offset;
      if (inPeriAlias(a)) begin
         offset = a - bitband_pkg::PERI_ALIAS_BASE;
      end else begin
         offset = a - bitband_pkg::SRAM_ALIAS_BASE;
      end
      return offset;
   endfunction : aliasOffset

   // band byte that an alias word stands for: offset / 32
   function automatic logic [31:0] bandByte(input logic [31:0] a);
      logic [31:0] offset;
      logic [31:0] base;
      offset = aliasOffset(a);
      if (inPeriAlias(a)) begin
         base = bitband_pkg::PERI_BAND_BASE;
      end else begin
         base = bitband_pkg::SRAM_BAND_BASE;
      end
      return base + {12'h000, offset[bitband_pkg::ALIAS_BYTE_LSB +: bitband_pkg::BAND_OFFSET_BITS]};
   endfunction : bandByte

   // lane of the byte times eight plus bit number; band bases are word aligned
   function automatic logic [4:0] bitIndex(input logic [31:0] a);
      logic [31:0] offset;
      offset = aliasOffset(a);
      return {offset[bitband_pkg::ALIAS_BYTE_LSB +: 2], offset[bitband_pkg::ALIAS_BIT_LSB +: 3]};
   endfunction : bitIndex

   // address of the access that holds the band byte, at the alias size
   function automatic logic [31:0] alignAddr(
      input logic [31:0] a,
      input logic [1:0] size
   );
      logic [31:0] aligned;
      case (size)
         bitband_pkg::SIZE_BYTE: begin
            aligned = a;
         end
         bitband_pkg::SIZE_HALF: begin
            aligned = {a[31:1], 1'b0};
         end
         default: begin
            aligned = {a[31:2], 2'h0};
         end
      endcase
      return aligned;
   endfunction : alignAddr

   assign upRdy = (stateReg == bitband_pkg::ST_IDLE);
   assign take = upVld && upRdy;
   assign upDone = (stateReg == bitband_pkg::ST_DONE);
   assign upAns = ansReg;

   // request stays put for the whole read-modify-write
   bitband_hold u_bitband_hold (
      .mclk(mclk),
      .rst(rst),
      .load(take),
      .din(upReq),
      .dout(held)
   );

   assign heldAlias = isAlias(held.addr) && !held.fetch;
   assign targetAddr = alignAddr(bandByte(held.addr), held.size);
   assign bitIdx = bitIndex(held.addr);

   // only bit 0 of the alias data reaches memory
   always_comb begin
      wbData = rdReg;
      wbData[bitIdx] = held.wdata[0];
   end

   assign dnVld = ((stateReg == bitband_pkg::ST_PASS) ||
                   (stateReg == bitband_pkg::ST_RD) ||
                   (stateReg == bitband_pkg::ST_WR)) && !issuedReg;

   always_comb begin
      dnReq = held;
      case (stateReg)
         bitband_pkg::ST_RD: begin
            dnReq.addr = targetAddr;
            dnReq.write = 1'b0;
            dnReq.fetch = 1'b0;
            dnReq.wdata = 32'h0000_0000;
         end
         bitband_pkg::ST_WR: begin
            dnReq.addr = targetAddr;
            dnReq.write = 1'b1;
            dnReq.fetch = 1'b0;
            dnReq.wdata = wbData;
         end
         default: begin
         end
      endcase
   end

   always_comb begin
      stateNext = stateReg;
      issuedNext = issuedReg;
      rdNext = rdReg;
      ansNext = ansReg;
      if (dnVld && dnRdy) begin
         issuedNext = 1'b1;
      end
      case (stateReg)
         bitband_pkg::ST_IDLE: begin
            issuedNext = 1'b0;
            if (take) begin
               if (upReq.fetch && isPeriRegion(upReq.addr)) begin
                  // fetch from device memory is refused without a memory access
                  ansNext.rdata = bitband_pkg::ALIAS_READ_CLEAR;
                  ansNext.error = 1'b1;
                  stateNext = bitband_pkg::ST_DONE;
               end else if (!upReq.fetch && isAlias(upReq.addr)) begin
                  stateNext = bitband_pkg::ST_RD;
               end else begin
                  stateNext = bitband_pkg::ST_PASS;
               end
            end
         end
         bitband_pkg::ST_PASS: begin
            if (issuedReg && dnDone) begin
               ansNext = dnAns;
               issuedNext = 1'b0;
               stateNext = bitband_pkg::ST_DONE;
            end
         end
         bitband_pkg::ST_RD: begin
            if (issuedReg && dnDone) begin
               rdNext = dnAns.rdata;
               issuedNext = 1'b0;
               if (held.write && !dnAns.error) begin
                  stateNext = bitband_pkg::ST_WR;
               end else if (held.write) begin
                  // failed read: no write back, so no other bit is disturbed
                  ansNext.rdata = bitband_pkg::ALIAS_READ_CLEAR;
                  ansNext.error = 1'b1;
                  stateNext = bitband_pkg::ST_DONE;
               end else begin
                  if (dnAns.rdata[bitIdx]) begin
                     ansNext.rdata = bitband_pkg::ALIAS_READ_SET;
                  end else begin
                     ansNext.rdata = bitband_pkg::ALIAS_READ_CLEAR;
                  end
                  ansNext.error = dnAns.error;
                  stateNext = bitband_pkg::ST_DONE;
               end
            end
         end
         bitband_pkg::ST_WR: begin
            if (issuedReg && dnDone) begin
               ansNext.rdata = bitband_pkg::ALIAS_READ_CLEAR;
               ansNext.error = dnAns.error;
               issuedNext = 1'b0;
               stateNext = bitband_pkg::ST_DONE;
            end
         end
         bitband_pkg::ST_DONE: begin
            issuedNext = 1'b0;
            stateNext = bitband_pkg::ST_IDLE;
         end
         default: begin
            issuedNext = 1'b0;
            stateNext = bitband_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         stateReg <= bitband_pkg::ST_IDLE;
         issuedReg <= 1'b0;
         rdReg <= 32'h0000_0000;
         ansReg <= '0;
      end else begin
         stateReg <= stateNext;
         issuedReg <= issuedNext;
         rdReg <= rdNext;
         ansReg <= ansNext;
      end
   end

   chk_fetch_refused: assert property (@(posedge mclk) disable iff (rst)
      take && upReq.fetch && isPeriRegion(upReq.addr) |=> upDone && upAns.error)
      else $error("device fetch not refused");

   chk_no_device_fetch: assert property (@(posedge mclk) disable iff (rst)
      dnVld |-> !(dnReq.fetch && isPeriRegion(dnReq.addr)))
      else $error("fetch reached device memory");

   chk_pass_intact: assert property (@(posedge mclk) disable iff (rst)
      take && !(isAlias(upReq.addr) && !upReq.fetch) && !(upReq.fetch && isPeriRegion(upReq.addr))
      |=> dnVld && (dnReq == $past(upReq)))
      else $error("pass through access altered");

   chk_size_kept: assert property (@(posedge mclk) disable iff (rst)
      dnVld && (stateReg != bitband_pkg::ST_PASS) |-> dnReq.size == held.size)
      else $error("remapped size differs");

   chk_band_target: assert property (@(posedge mclk) disable iff (rst)
      dnVld && (stateReg == bitband_pkg::ST_RD)
      |-> inRange(dnReq.addr, bitband_pkg::SRAM_BAND_BASE, bitband_pkg::SRAM_BAND_LAST) ||
          inRange(dnReq.addr, bitband_pkg::PERI_BAND_BASE, bitband_pkg::PERI_BAND_LAST))
      else $error("remapped access outside band");

   chk_one_bit_change: assert property (@(posedge mclk) disable iff (rst)
      dnVld && (stateReg == bitband_pkg::ST_WR) |-> $onehot0(dnReq.wdata ^ rdReg))
      else $error("write back changes more than one bit");

   chk_new_bit_value: assert property (@(posedge mclk) disable iff (rst)
      dnVld && (stateReg == bitband_pkg::ST_WR) |-> dnReq.wdata[bitIdx] == held.wdata[0])
      else $error("target bit not taken from data bit 0");

   chk_read_shape: assert property (@(posedge mclk) disable iff (rst)
      upDone && heldAlias && !held.write |-> upAns.rdata[31:1] == 31'h0000_0000)
      else $error("alias read upper bits not zero");

   cov_alias_write: cover property (@(posedge mclk) disable iff (rst)
      dnVld && (stateReg == bitband_pkg::ST_WR));

   cov_alias_read: cover property (@(posedge mclk) disable iff (rst)
      upDone && heldAlias && !held.write);

   cov_refused: cover property (@(posedge mclk) disable iff (rst)
      upDone && upAns.error);

   cov_pass: cover property (@(posedge mclk) disable iff (rst)
      upDone && !heldAlias && !upAns.error);
endmodule : bit_band_alias_remapper
`default_nettype wire

// ---- bench/mem_model.sv ----
// word memory behind the remapper
// assumes one request at a time, answered next cycle
`timescale 1ns/1ps
`default_nettype none
module mem_model (
   input wire logic mclk,
   input wire logic dnVld,
   output logic dnRdy,
   input wire bitband_pkg::request_t dnReq,
   output logic dnDone,
   output bitband_pkg::answer_t dnAns
);
   logic [31:0] mem [logic [29:0]];
   assign dnRdy = 1'b1;
   always @(posedge mclk) begin
      dnDone <= dnVld;
      if (dnVld && dnReq.write) mem[dnReq.addr[31:2]] = dnReq.wdata;
      if (dnVld && dnReq.write) dnAns <= '0;
      else if (dnVld) dnAns <= {mem.exists(dnReq.addr[31:2]) ? mem[dnReq.addr[31:2]] : 32'h0, 1'b0};
      else dnAns <= ~dnAns; // stale data must never look valid
   end
endmodule : mem_model
`default_nettype wire

// ---- bench/bit_band_alias_remapper_test.sv ----
// bench for the alias remapper
// assumes mem_model answers every request
`timescale 1ns/1ps
`default_nettype none
module bit_band_alias_remapper_test;
   logic mclk = 0, rst = 1, upVld = 0, upRdy, upDone, dnVld, dnRdy, dnDone;
   bitband_pkg::request_t upReq = '0, dnReq;
   bitband_pkg::answer_t upAns, dnAns, e, q[$];
   logic [1:0] sz;
   int bad_count = 0, tests_run = 0, i, d, j;
   initial forever #25 mclk = ~mclk;
   bit_band_alias_remapper u_bit_band_alias_remapper (
      .mclk(mclk), .rst(rst), .upVld(upVld), .upRdy(upRdy), .upReq(upReq), .upDone(upDone), .upAns(upAns),
      .dnVld(dnVld), .dnRdy(dnRdy), .dnReq(dnReq), .dnDone(dnDone), .dnAns(dnAns)
   );
   mem_model u_mem_model (
      .mclk(mclk), .dnVld(dnVld), .dnRdy(dnRdy), .dnReq(dnReq), .dnDone(dnDone), .dnAns(dnAns)
   );
   task go(input logic [31:0] a, input logic [1:0] s, input logic w, input logic f, input logic [31:0] wd,
           input bitband_pkg::answer_t x);
      q.push_back(x);
      @(posedge mclk);
      upVld <= 1'b1;
      upReq <= {a, s, w, f, wd};
      do @(posedge mclk); while (upRdy !== 1'b1);
      upVld <= 1'b0;
      wait (q.size() == 0);
   endtask : go
   always @(posedge mclk) if (upDone === 1'b1) begin
      tests_run++;
      if (q.size() == 0) begin
         bad_count++;
         $display("Error %0t answer without request", $time);
      end else begin
         e = q.pop_front();
         if (upAns !== e) begin
            bad_count++;
            $display("Error %0t answer %h expected %h", $time, upAns, e);
         end
      end
   end
   task finish_test;
      $display("tests %0d bad %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : finish_test
   initial begin #300000 bad_count++; finish_test; end
   initial begin
      i = $urandom(86);
      repeat (2) @(posedge mclk);
      rst <= 0;
      for (int k = 0; k < 8; k++) begin
         i = {13'($urandom % 8192), 3'(k), 2'h0};
         sz = 2'($urandom % 3);
         d = $urandom;
         j = $urandom % 4;
         go(bitband_pkg::SRAM_ALIAS_BASE + i, sz, 1, 0, 32'h0000_00FF, '0);
         go(bitband_pkg::SRAM_ALIAS_BASE + i, sz, 0, 0, 32'h0, 33'h2);
         go(bitband_pkg::SRAM_ALIAS_BASE + i, sz, 0, 1, 32'h0, 33'h0);
         go(bitband_pkg::SRAM_ALIAS_BASE + i, sz, 1, 0, 32'h0000_000E, '0);
         go(bitband_pkg::SRAM_ALIAS_BASE + i, sz, 0, 0, 32'h0, 33'h0);
         go(bitband_pkg::SRAM_BAND_BASE + 32'h10, bitband_pkg::SIZE_WORD, 1, 0, d, '0);
         go(bitband_pkg::SRAM_BAND_BASE + 32'h10, bitband_pkg::SIZE_WORD, 0, 0, 32'h0, {d, 1'b0});
         go(bitband_pkg::SRAM_ALIAS_BASE + 32'((16 + j) * 32 + k * 4), bitband_pkg::SIZE_WORD, 0, 0, 32'h0,
            {31'h0, d[j * 8 + k], 1'b0});
         i = {20'($urandom), 3'(k), 2'h0};
         go(bitband_pkg::PERI_ALIAS_BASE + i, sz, 1, 0, 32'h0000_0003, '0);
         go(bitband_pkg::PERI_ALIAS_BASE + i, sz, 0, 0, 32'h0, 33'h2);
         $display("test %0d done", k);
      end
      go(bitband_pkg::PERI_ALIAS_BASE, bitband_pkg::SIZE_WORD, 0, 1, 32'h0, 33'h1);
      go(bitband_pkg::PERI_BAND_BASE, bitband_pkg::SIZE_WORD, 0, 1, 32'h0, 33'h1);
      finish_test;
   end
endmodule : bit_band_alias_remapper_test
`default_nettype wire
